// *** logic/sts_core.sv ***
// Safety-switch sequencer with an APB register slave.
// Assumes asynchronous pins; rst models the supply switching on.
//
// Register access over APB and the address map were left to the implementer.
`default_nettype none
// Contract
// RULE_01: Start button held at least 250 ms to count.
// RULE_02: Relays close 200 to 300 ms after a valid press.
// RULE_03: Relays off, monitors low in the ready delay.
// RULE_04: Green lamp blinks about 15 Hz in the ready delay.
// RULE_05: Internal fault opens the relays in the fault time.
// RULE_06: A weld is found at the next guard opening.
// RULE_07: Actuator removal opens the relays in the switch delay.
// RULE_08: Switch-off limit 210 to 450 ms by actuator count.
// RULE_09: With feedback, actuators stay away until the loop closes.
// RULE_10: Teach-in stores heads, identities, start mode, feedback.
// RULE_11: Teach-in only with the jumper fitted before power-up.
// RULE_12: Switches 1 to 4 mark the fitted heads.
// RULE_13: Switch 5 picks automatic or manual start.
// RULE_14: Switch 6 picks feedback loop monitoring.
// RULE_15: Teach-in: doors closed, start held if manual, loop closed. The code checks the loop only when switch 6 is set.
// RULE_16: Jumper boot: self-test, 1 Hz teach blink, then lamp off.
// RULE_17: Leave teach-in: power off, jumper out, rewire, power on.
// RULE_18: Door change in teach-in: fault with three-flash bursts.
// RULE_19: Teach-in repeats freely, replacing all configuration.
// RULE_20: An untaught actuator is not recognised.
// RULE_21: Switches are not changed while running.
// RULE_22: Switches unlike the taught ones give a configuration fault.
// RULE_23: Test input: relays off, diagnostic high; release resumes.
// RULE_24: Each head's identity is checked against its stored one.
module sts_core #(
    parameter int unsigned READY_CYC      = sts_pkg::READY_CYC,
    parameter int unsigned TEACH_CYC      = sts_pkg::TEACH_CYC,
    parameter int unsigned START_HOLD_CYC = sts_pkg::START_HOLD_CYC,
    parameter int unsigned START_RESP_CYC = sts_pkg::START_RESP_CYC,
    parameter int unsigned SETTLE_CYC     = sts_pkg::SETTLE_CYC,
    parameter int unsigned READY_HALF_CYC = sts_pkg::READY_HALF_CYC,
    parameter int unsigned TEACH_HALF_CYC = sts_pkg::TEACH_HALF_CYC,
    parameter int unsigned FLASH_SLOT_CYC = sts_pkg::FLASH_SLOT_CYC
) (
    input  wire logic        clock,                   // Clock
    input  wire logic        rst,                     // Supply start-up reset
    input  wire logic [7:0]  paddr,                   // APB address
    input  wire logic        psel,                    // APB select
    input  wire logic        penable,                 // APB enable
    input  wire logic        pwrite,                  // APB write
    input  wire logic [31:0] pwdata,                  // APB write data
    output logic      [31:0] prdata,                  // APB read data
    output logic             pready,                  // APB ready
    output logic             pslverr,                 // APB error
    input  wire logic [3:0]  head_present,            // In range per head
    input  wire logic [31:0] head_id,                 // Identity per head
    input  wire logic [5:0]  config_switch,           // Switches 1 to 6 from bit 0
    input  wire logic        teach_jumper_terminal_a, // Jumper a
    input  wire logic        teach_jumper_terminal_b, // Jumper b
    input  wire logic        start_button,            // Start button
    input  wire logic        feedback_loop_terminals, // Feedback loop closed
    input  wire logic        function_test_input,     // Function test input
    input  wire logic        internal_fault,          // Internal fault
    input  wire logic [1:0]  relay_contact_closed,    // Contact readback
    output logic      [1:0]  relay_out,               // Relay drives
    output logic             enable_output,           // Circuit closed
    output logic             diagnostic_output,       // Diagnostic
    output logic             green_status_lamp,       // State lamp
    output logic             out_lamp                 // Closed lamp
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [sts_pkg::SYNC_W-1:0] sync1;
    logic [sts_pkg::SYNC_W-1:0] sync2;
    wire  [sts_pkg::SYNC_W-1:0] raw_pins = {head_present, head_id, config_switch,
        teach_jumper_terminal_a, teach_jumper_terminal_b, start_button,
        feedback_loop_terminals, function_test_input, internal_fault, relay_contact_closed};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw_pins;
            sync2 <= sync1;
        end
    end

    wire [3:0]  present_s  = sync2[49:46];
    wire [31:0] id_s       = sync2[45:14];
    wire [5:0]  cfg_s      = sync2[13:8];
    wire        jumper_s   = sync2[7] & sync2[6];
    wire        start_s    = sync2[5];
    wire        loop_s     = sync2[4];
    wire        tst_s      = sync2[3];
    wire        ifault_s   = sync2[2];
    wire [1:0]  relay_fb_s = sync2[1:0];

    ////////////////////////////////////////////////////////////////////////////////
    sts_pkg::sts_state_e state;
    sts_pkg::sts_state_e next_state;
    logic [31:0] timer;
    logic [31:0] start_cnt;
    logic [31:0] off_cnt;
    logic [31:0] blink_cnt;
    logic [31:0] slot_cnt;
    logic [3:0]  slot_idx;
    logic        blink_lvl;
    logic        start_armed;
    logic        boot_jumper;
    logic [3:0]  door_snap;
    logic        soft_test;
    logic [6:0]  taught;
    logic [31:0] taught_ids;
    logic        relay_on;

    // Untaught channels never block the doors.
    wire [3:0] head_ok;
    genvar gi;
    generate
        for (gi = 0; gi < sts_pkg::HEADS; gi++) begin : g_head
            assign head_ok[gi] = !taught[gi] || (present_s[gi] &&
                id_s[gi*sts_pkg::ID_W +: sts_pkg::ID_W] ==
                taught_ids[gi*sts_pkg::ID_W +: sts_pkg::ID_W]); // RULE_20 RULE_24
        end
    endgenerate

    wire doors_ok   = (&head_ok) && (taught[3:0] != 4'h0);        // RULE_07
    wire test_on    = tst_s | soft_test;                          // RULE_23
    wire cfg_fault  = !taught[sts_pkg::CFG_VALID] || jumper_s ||
                      (cfg_s != taught[5:0]);                     // RULE_21 RULE_22
    wire manual     = taught[sts_pkg::CFG_MANUAL];                // RULE_13
    wire loop_ok    = !taught[sts_pkg::CFG_FEEDBACK] || loop_s;   // RULE_09 RULE_14
    wire in_run     = (state == sts_pkg::S_RUN_OPEN) || (state == sts_pkg::S_START_DELAY) ||
                      (state == sts_pkg::S_RUN_CLOSED);
    // Weld is checked only after the relays are commanded off.
    wire weld       = in_run && (off_cnt == SETTLE_CYC) && (|relay_fb_s); // RULE_06
    wire run_fault  = ifault_s || cfg_fault || weld;              // RULE_05
    wire teach_ok   = (cfg_s[3:0] != 4'h0) && (cfg_s[3:0] == present_s) &&
                      (!cfg_s[sts_pkg::CFG_MANUAL] || start_s) &&
                      (!cfg_s[sts_pkg::CFG_FEEDBACK] || loop_s);  // RULE_12 RULE_15
    wire start_done = start_armed && (start_cnt == START_HOLD_CYC - 1); // RULE_01
    wire st_change  = next_state != state;

    always_comb begin
        next_state = state;
        case (state)
            sts_pkg::S_SELFTEST: begin
                if (timer == READY_CYC - 1) begin
                    next_state = boot_jumper ? sts_pkg::S_TEACH : sts_pkg::S_RUN_OPEN; // RULE_11
                end
            end
            sts_pkg::S_TEACH: begin
                if (ifault_s || present_s != door_snap) begin
                    next_state = sts_pkg::S_FAULT;                // RULE_18
                end else if (timer == TEACH_CYC - 1) begin
                    next_state = teach_ok ? sts_pkg::S_TEACH_DONE : sts_pkg::S_FAULT;
                end
            end
            sts_pkg::S_TEACH_DONE: begin
                next_state = sts_pkg::S_TEACH_DONE;
            end
            sts_pkg::S_RUN_OPEN: begin
                if (run_fault) begin
                    next_state = sts_pkg::S_FAULT;
                end else if (doors_ok && loop_ok && !test_on && (!manual || start_done)) begin
                    next_state = manual ? sts_pkg::S_START_DELAY : sts_pkg::S_RUN_CLOSED;
                end
            end
            sts_pkg::S_START_DELAY: begin
                if (run_fault) begin
                    next_state = sts_pkg::S_FAULT;
                end else if (!doors_ok || test_on) begin
                    next_state = sts_pkg::S_RUN_OPEN;
                end else if (timer == START_RESP_CYC - 1) begin
                    next_state = sts_pkg::S_RUN_CLOSED;           // RULE_02
                end
            end
            sts_pkg::S_RUN_CLOSED: begin
                if (run_fault) begin
                    next_state = sts_pkg::S_FAULT;
                end else if (!doors_ok || test_on) begin
                    next_state = sts_pkg::S_RUN_OPEN;             // RULE_07 RULE_08
                end
            end
            sts_pkg::S_FAULT: begin
                next_state = sts_pkg::S_FAULT;
            end
            default: begin
                next_state = sts_pkg::S_FAULT;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= sts_pkg::S_SELFTEST;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= st_change ? 32'h0 : timer + 32'h1;
        end
    end

    // Jumper sampled once after start-up; fitting it later never teaches.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boot_jumper <= 1'b0;
            door_snap   <= 4'h0;
        end else begin
            if (state == sts_pkg::S_SELFTEST && timer == sts_pkg::JUMPER_SAMPLE) begin
                boot_jumper <= jumper_s;                          // RULE_11
            end
            if (state == sts_pkg::S_SELFTEST && next_state == sts_pkg::S_TEACH) begin
                door_snap <= present_s;
            end
        end
    end

    // A button held since reset, or after a counted press, must be released first.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_armed <= 1'b0;
            start_cnt   <= '0;
        end else begin
            start_armed <= !start_s ? 1'b1 : (start_done ? 1'b0 : start_armed);
            start_cnt   <= (start_s && start_armed && !start_done && doors_ok) ?
                           start_cnt + 32'h1 : 32'h0; // RULE_01
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            off_cnt <= '0;
        end else if (relay_on) begin
            off_cnt <= '0;
        end else if (off_cnt != SETTLE_CYC) begin
            off_cnt <= off_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wire [31:0] half_cyc = (state == sts_pkg::S_TEACH) ? TEACH_HALF_CYC : READY_HALF_CYC;
    wire        flash_on = (slot_idx <= sts_pkg::FLASH_LAST_ON) && !slot_idx[0]; // RULE_18

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            blink_cnt <= '0;
            blink_lvl <= 1'b0;
            slot_cnt  <= '0;
            slot_idx  <= 4'h0;
        end else begin
            if (st_change || blink_cnt == half_cyc - 1) begin
                blink_cnt <= '0;
                blink_lvl <= st_change ? 1'b1 : !blink_lvl;       // RULE_04 RULE_16
            end else begin
                blink_cnt <= blink_cnt + 32'h1;
            end
            if (st_change || slot_cnt == FLASH_SLOT_CYC - 1) begin
                slot_cnt <= '0;
                slot_idx <= (st_change || slot_idx == sts_pkg::FLASH_SLOTS - 4'h1) ?
                            4'h0 : slot_idx + 4'h1;
            end else begin
                slot_cnt <= slot_cnt + 32'h1;
            end
        end
    end

    wire next_relay = (state == sts_pkg::S_RUN_CLOSED) && (next_state == sts_pkg::S_RUN_CLOSED);
    wire next_diag  = (state == sts_pkg::S_FAULT) || (in_run && test_on); // RULE_23
    wire next_lamp  = (state == sts_pkg::S_SELFTEST || state == sts_pkg::S_TEACH) ? blink_lvl :
                      (state == sts_pkg::S_TEACH_DONE) ? 1'b0 :
                      (state == sts_pkg::S_FAULT) ? flash_on : 1'b1;      // RULE_16

    // Relays and monitors stay low outside the run states, except diagnostic, which is high in S_FAULT.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            relay_on          <= 1'b0;                            // RULE_03
            diagnostic_output <= 1'b0;
            green_status_lamp <= 1'b0;
        end else begin
            relay_on          <= next_relay;                      // RULE_05 RULE_07
            diagnostic_output <= next_diag;
            green_status_lamp <= next_lamp;
        end
    end

    assign relay_out     = {relay_on, relay_on};
    assign enable_output = relay_on;
    assign out_lamp      = relay_on;

    ////////////////////////////////////////////////////////////////////////////////
    wire setup   = psel && !penable;
    wire wr      = psel && penable && pwrite;
    wire hit     = (paddr == sts_pkg::ADDR_CTRL) || (paddr == sts_pkg::ADDR_STATUS) ||
                   (paddr == sts_pkg::ADDR_TAUGHT) || (paddr == sts_pkg::ADDR_IDS);
    // The stored image may be restored only during self-test.
    wire sw_load = wr && (state == sts_pkg::S_SELFTEST);
    wire hw_load = (state == sts_pkg::S_TEACH) && (next_state == sts_pkg::S_TEACH_DONE);
    wire [31:0] status_word = {17'h0, 3'(state), boot_jumper, test_on, loop_s,
                               start_s, doors_ok, relay_on, relay_fb_s, present_s};
    wire [31:0] rd_mux = (paddr == sts_pkg::ADDR_CTRL)   ? {31'h0, soft_test} :
                         (paddr == sts_pkg::ADDR_STATUS) ? status_word :
                         (paddr == sts_pkg::ADDR_TAUGHT) ? {25'h0, taught} :
                         (paddr == sts_pkg::ADDR_IDS)    ? taught_ids : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Teach-in writes the whole image, so a repeat replaces it all.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            soft_test  <= 1'b0;
            taught     <= 7'h00;
            taught_ids <= '0;
            prdata     <= '0;
        end else begin
            if (setup) begin
                prdata <= rd_mux;
            end
            if (wr && paddr == sts_pkg::ADDR_CTRL) begin
                soft_test <= pwdata[0];                           // RULE_23
            end
            if (hw_load) begin
                taught     <= {1'b1, cfg_s};                      // RULE_10 RULE_19
                taught_ids <= id_s;                               // RULE_10 RULE_20
            end else if (sw_load && paddr == sts_pkg::ADDR_TAUGHT) begin
                taught <= pwdata[6:0];
            end else if (sw_load && paddr == sts_pkg::ADDR_IDS) begin
                taught_ids <= pwdata;
            end
        end
    end
endmodule : sts_core
`default_nettype wire

// *** logic/sts_pkg.sv ***
// Constants and types of the teach-in sequencer.
// Assumes a 100 MHz clock; times in ms, counts in cycles.
`default_nettype none
package sts_pkg;
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned READY_MS       = 10000;
    localparam int unsigned TEACH_MS       = 10000;
    localparam int unsigned START_HOLD_MS  = 250;
    localparam int unsigned START_RESP_MS  = 200;
    localparam int unsigned SETTLE_MS      = 20;
    localparam int unsigned READY_BLINK_HZ = 15;
    localparam int unsigned TEACH_BLINK_HZ = 1;
    localparam int unsigned FLASH_SLOT_MS  = 100;
    localparam int unsigned READY_CYC      = READY_MS * CYC_PER_MS;
    localparam int unsigned TEACH_CYC      = TEACH_MS * CYC_PER_MS;
    localparam int unsigned START_HOLD_CYC = START_HOLD_MS * CYC_PER_MS;
    localparam int unsigned START_RESP_CYC = START_RESP_MS * CYC_PER_MS;
    localparam int unsigned SETTLE_CYC     = SETTLE_MS * CYC_PER_MS;
    localparam int unsigned READY_HALF_CYC = CLK_HZ / (2 * READY_BLINK_HZ);
    localparam int unsigned TEACH_HALF_CYC = CLK_HZ / (2 * TEACH_BLINK_HZ);
    localparam int unsigned FLASH_SLOT_CYC = FLASH_SLOT_MS * CYC_PER_MS;
    localparam logic [3:0]  FLASH_SLOTS    = 4'ha;
    localparam logic [3:0]  FLASH_LAST_ON  = 4'h4;
    localparam logic [31:0] JUMPER_SAMPLE  = 32'h0000_0004;
    localparam int unsigned HEADS          = 4;
    localparam int unsigned ID_W           = 8;
    localparam int unsigned SYNC_W         = 50;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_TAUGHT    = 8'h08;
    localparam logic [7:0]  ADDR_IDS       = 8'h0c;
    localparam int unsigned CFG_MANUAL     = 4;
    localparam int unsigned CFG_FEEDBACK   = 5;
    localparam int unsigned CFG_VALID      = 6;
    typedef enum logic [2:0] {
        S_SELFTEST, S_TEACH, S_TEACH_DONE, S_RUN_OPEN, S_START_DELAY, S_RUN_CLOSED, S_FAULT
    } sts_state_e;
endpackage : sts_pkg
`default_nettype wire

// *** testbench/sts_checker.sv ***
// Port assertions, bound into sts_core.
// Assumes the bind passes the ready and blink counts.
`default_nettype none
module sts_checker #(
    parameter int unsigned READY_CYC      = 200,
    parameter int unsigned READY_HALF_CYC = 4
) (
    input wire logic       clock,                // Clock
    input wire logic       rst,                  // Reset
    input wire logic [7:0] paddr,                // APB address
    input wire logic       psel,                 // APB select
    input wire logic       penable,              // APB enable
    input wire logic       pready,               // APB ready
    input wire logic       pslverr,              // APB error
    input wire logic [3:0] head_present,         // In range
    input wire logic       function_test_input,  // Test
    input wire logic       internal_fault,       // Fault
    input wire logic [1:0] relay_contact_closed, // Readback
    input wire logic [1:0] relay_out,            // Relays
    input wire logic       diagnostic_output,    // Diagnostic
    input wire logic       green_status_lamp,    // Status lamp
    input wire logic       out_lamp              // Enable lamp
);
    // Saturates, so a long run never re-enters the ready window.
    logic [15:0] cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) cnt <= 16'h0000;
        else if (cnt != 16'hffff) cnt <= cnt + 16'h0001;
    end
    ////////////////////////////////////////////////////////////
    chk_ready_quiet: assert property (cnt < READY_CYC |-> relay_out == 2'b00
        && !diagnostic_output && !out_lamp) else $error("Outputs active in ready delay.");
    chk_ready_blink: assert property (cnt > 16 && cnt < READY_CYC - 8 |->
        green_status_lamp != $past(green_status_lamp, READY_HALF_CYC)) else $error("No blink.");
    chk_test_off: assert property (function_test_input [*5] |-> relay_out == 2'b00)
        else $error("Relays closed under test.");
    chk_fault_open: assert property (internal_fault [*5] |-> relay_out == 2'b00)
        else $error("Relays closed under fault.");
    chk_door_open: assert property ((head_present == 4'h0) [*5] |-> relay_out == 2'b00)
        else $error("Relays closed with no actuator.");
    chk_weld_fault: assert property ($fell(relay_out[0]) ##1 relay_contact_closed[0] [*8]
        |-> ##[0:4] diagnostic_output) else $error("Weld not reported.");
    chk_apb_ready: assert property (psel && penable |-> pready) else $error("Access stalled.");
    chk_apb_error: assert property (psel && penable |-> pslverr == !(paddr inside
        {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("Wrong error response.");
    cov_closed: cover property ($rose(relay_out[0]));
    cov_diag: cover property ($rose(diagnostic_output));
    cov_unmapped: cover property (psel && penable && pslverr);
endmodule : sts_checker
bind sts_core sts_checker #(.READY_CYC(READY_CYC), .READY_HALF_CYC(READY_HALF_CYC)) u_chk (
    .clock, .rst, .paddr, .psel, .penable, .pready, .pslverr, .head_present,
    .function_test_input, .internal_fault, .relay_contact_closed, .relay_out,
    .diagnostic_output, .green_status_lamp, .out_lamp);
`default_nettype wire

// *** testbench/sts_partner.sv ***
// Far side: read heads, actuators and relay contact readback.
// Assumes the bench changes door, swap and weld at rising clock edges.
`default_nettype none
module sts_partner (
    input  wire logic        clock,                // Clock
    input  wire logic [3:0]  door,                 // Door closed
    input  wire logic [3:0]  swap,                 // Foreign actuator
    input  wire logic [31:0] ids,                  // Actuator identities
    input  wire logic        weld,                 // Contacts stuck
    input  wire logic [1:0]  relay_out,            // Relay drives
    output logic      [3:0]  head_present,         // In range
    output logic      [31:0] head_id,              // Identity seen
    output logic      [1:0]  relay_contact_closed  // Readback
);
    logic [1:0] drive_q;
    always_ff @(posedge clock) drive_q <= relay_out;
    assign relay_contact_closed = weld ? 2'b11 : drive_q;
    assign head_present = door;
    // Absent or foreign heads show the inverse identity.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            head_id[8*i +: 8] = (door[i] && !swap[i]) ? ids[8*i +: 8] : ~ids[8*i +: 8];
        end
    end
endmodule : sts_partner
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench of the sequencer, shortened timing.
// Assumes the checker binds itself and sts_partner models the far side.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned READY = 200;
    localparam int unsigned TEACH = 200;
    localparam int unsigned HOLD  = 20;
    localparam int unsigned RESP  = 10;
    logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        jump = 1'b0, start = 1'b0, loop = 1'b0, test_in = 1'b0, ifault = 1'b0;
    logic        weld = 1'b0, pready, pslverr, enable_output, diag, lamp, out_lamp;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ids = 32'h0, head_id;
    logic [3:0]  door = 4'h0, swap = 4'h0, head_present;
    logic [5:0]  sw = 6'h00;
    logic [1:0]  relay_out, contacts;
    int          num_errors = 0, comparisons = 0, cycles = 0;
    sts_core #(.READY_CYC(READY), .TEACH_CYC(TEACH), .START_HOLD_CYC(HOLD),
        .START_RESP_CYC(RESP), .SETTLE_CYC(5), .READY_HALF_CYC(4), .TEACH_HALF_CYC(8),
        .FLASH_SLOT_CYC(4)) DUT (.clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .head_present, .head_id, .config_switch(sw),
        .teach_jumper_terminal_a(jump), .teach_jumper_terminal_b(jump), .start_button(start),
        .feedback_loop_terminals(loop), .function_test_input(test_in), .internal_fault(ifault),
        .relay_contact_closed(contacts), .relay_out, .enable_output,
        .diagnostic_output(diag), .green_status_lamp(lamp), .out_lamp);
    sts_partner u_far (.clock, .door, .swap, .ids, .weld, .relay_out, .head_present,
        .head_id, .relay_contact_closed(contacts));
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clock);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = {prdata[31:1], prdata[0] | pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits up to n edges for relays (sel 0) or diagnostic (sel 1) to reach e.
    task automatic await(input logic sel, input logic [1:0] e, input int n, input string w);
        for (int k = 0; k < n; k++) begin
            if ((sel ? {1'b0, diag} : relay_out) === e) break;
            @(posedge clock);
        end
        chk(sel ? {31'h0, diag} : {28'h0, enable_output, out_lamp, relay_out},
            sel ? {30'h0, e} : {28'h0, e[0], e[0], e}, w);
    endtask : await
    // A normal boot restores the stored image during self-test.
    task automatic boot(input logic j, input logic [5:0] s, input logic [31:0] t);
        logic [31:0] q;
        jump <= j;
        sw <= s;
        rst <= 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        if (!j) begin
            apb(1'b1, sts_pkg::ADDR_TAUGHT, t, q);
            apb(1'b1, sts_pkg::ADDR_IDS, ids, q);
            apb(1'b0, sts_pkg::ADDR_TAUGHT, 32'h0, q);
            chk(q, t, "image");
        end
        repeat (READY) @(posedge clock);
    endtask : boot
    function automatic logic [31:0] model_image(input logic [5:0] s);
        return {25'h0, 1'b1, s};
    endfunction : model_image
    ////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic        l0;
        int          n;
        ids = $urandom(32'hd3eb);
        door <= 4'h3;
        boot(1'b0, 6'h03, 32'h43);
        await(1'b0, 2'b11, 12, "auto start");
        apb(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h1, "unmapped");
        swap <= 4'h2;
        await(1'b0, 2'b00, 8, "foreign");
        swap <= 4'h0;
        await(1'b0, 2'b11, 12, "back");
        test_in <= 1'b1;
        await(1'b1, 2'b01, 8, "test diag");
        await(1'b0, 2'b00, 8, "test relays");
        repeat (4) @(posedge clock);
        test_in <= 1'b0;
        await(1'b1, 2'b00, 8, "released");
        await(1'b0, 2'b11, 12, "resumed");
        door <= 4'h1;
        await(1'b0, 2'b00, 8, "door open");
        door <= 4'h3;
        await(1'b0, 2'b11, 12, "closed");
        weld <= 1'b1;
        door <= 4'h0;
        await(1'b1, 2'b01, 20, "weld");
        apb(1'b0, sts_pkg::ADDR_STATUS, 32'h0, q);
        chk({29'h0, q[14:12]}, 32'h6, "fault state");
        weld <= 1'b0;
        door <= 4'h3;
        boot(1'b0, 6'h13, 32'h53);
        await(1'b0, 2'b00, 1, "manual idle");
        start <= 1'b1;
        repeat (HOLD / 2) @(posedge clock);
        start <= 1'b0;
        repeat (HOLD + RESP + 8) @(posedge clock);
        await(1'b0, 2'b00, 1, "short press");
        n = HOLD + 2 + $urandom % 8;
        start <= 1'b1;
        repeat (n) @(posedge clock);
        start <= 1'b0;
        await(1'b0, 2'b11, RESP + 12, "long press");
        ifault <= 1'b1;
        await(1'b0, 2'b00, 8, "internal fault");
        repeat (6) @(posedge clock);
        ifault <= 1'b0;
        boot(1'b0, 6'h07, 32'h43);
        await(1'b1, 2'b01, 12, "switch differs");
        await(1'b0, 2'b00, 1, "kept safe");
        door <= 4'h5;
        loop <= 1'b1;
        ids <= $urandom;
        boot(1'b1, 6'h25, 32'h0);
        repeat (50) @(posedge clock);
        l0 = lamp;
        repeat (8) @(posedge clock);
        chk({31'h0, lamp}, {31'h0, ~l0}, "teach blink");
        repeat (TEACH) @(posedge clock);
        chk({31'h0, lamp}, 32'h0, "teach done");
        apb(1'b0, sts_pkg::ADDR_TAUGHT, 32'h0, q);
        chk(q, model_image(6'h25), "taught");
        apb(1'b0, sts_pkg::ADDR_IDS, 32'h0, q);
        chk(q & 32'h00ff00ff, ids & 32'h00ff00ff, "identities");
        boot(1'b1, 6'h25, 32'h0);
        repeat (50) @(posedge clock);
        door <= 4'h1;
        await(1'b1, 2'b01, 12, "disturbed");
        n = 0;
        repeat (40) begin
            @(posedge clock);
            n += int'(lamp);
        end
        chk(32'(n), 32'hc, "flashes");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
